// >>> hdl/ftc_pkg.sv
// Purpose: Shared constants for the FSK transmit control block
// Assumes: Wishbone classic bus, 32-bit data, byte addresses
// Notes:   Register indices are multiplied by four for byte addresses
package ftc_pkg;
   // Register indices and byte addresses
   localparam logic [3:0] FTC_IDX_CFG0   = 4'h0;
   localparam logic [3:0] FTC_IDX_CFG1   = 4'h1;
   localparam logic [3:0] FTC_IDX_DIV0   = 4'h2;
   localparam logic [3:0] FTC_IDX_DIV1   = 4'h3;
   localparam logic [3:0] FTC_IDX_FEE    = 4'h4;
   localparam logic [3:0] FTC_IDX_STAT   = 4'h5;
   localparam logic [5:0] FTC_ADR_CFG0   = {FTC_IDX_CFG0, 2'b00};
   localparam logic [5:0] FTC_ADR_CFG1   = {FTC_IDX_CFG1, 2'b00};
   localparam logic [5:0] FTC_ADR_DIV0   = {FTC_IDX_DIV0, 2'b00};
   localparam logic [5:0] FTC_ADR_DIV1   = {FTC_IDX_DIV1, 2'b00};
   localparam logic [5:0] FTC_ADR_FEE    = {FTC_IDX_FEE, 2'b00};
   localparam logic [5:0] FTC_ADR_STAT   = {FTC_IDX_STAT, 2'b00};
   // Config register 0 fields
   localparam int FTC_C0_LOW_NOISE_AMP_BYPASS  = 7;
   localparam int FTC_C0_PWR_HI  = 6;
   localparam int FTC_C0_PWR_LO  = 4;
   localparam int FTC_C0_SYNC    = 3;
   localparam int FTC_C0_MODE_HI = 2;
   localparam int FTC_C0_MODE_LO = 1;
   // Config register 1 fields
   localparam int FTC_C1_RSSI    = 3;
   localparam int FTC_C1_LD      = 2;
   // Fixed bits and reset values
   localparam logic [7:0] FTC_C0_FIXED = 8'h01;
   localparam logic [7:0] FTC_C1_FIXED = 8'h80;
   localparam logic [7:0] FTC_C0_RST   = 8'h01;
   localparam logic [7:0] FTC_C1_RST   = 8'h80;
   // Divider word: M in 23:16, N in 15:8, A in 7:0
   localparam logic [23:0] FTC_DIV_RST = 24'h00_0000;
   localparam int FTC_DIV_W = 24;
   // Operating mode encodings chosen for this block
   localparam logic [1:0] FTC_MODE_RX = 2'h1;
   localparam logic [1:0] FTC_MODE_TX = 2'h2;
   // Status bit positions
   localparam int FTC_ST_PA_ON  = 0;
   localparam int FTC_ST_AMPLIFIER_BYPASS  = 1;
   localparam int FTC_ST_DATA   = 2;
   localparam int FTC_ST_TXMODE = 3;
   // Power field value that turns the amplifier off
   localparam logic [2:0] FTC_PWR_OFF = 3'h0;
endpackage

// >>> hdl/ftc_wb_if.sv
// Purpose: Bundle joining the frequency error counter to the top
// Assumes: Single clock domain
// Notes:   Carries pulses in and the signed result out
`timescale 1ns/10ps
interface ftc_fee_if;
   logic       up;      // One pulse per up count
   logic       dn;      // One pulse per down count
   logic       clr;     // Restart measurement
   logic [7:0] result;  // Signed count
   modport ctr (input up, input dn, input clr, output result);
   modport top (output up, output dn, output clr, input result);
endinterface

// >>> hdl/ftc_fee_counter.sv
// Purpose: Eight-bit signed wrapping frequency error counter
// Assumes: Up and down are one-cycle pulses
// Notes:   Wraps freely past either limit
`timescale 1ns/10ps
module ftc_fee_counter
   import ftc_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   ftc_fee_if.ctr   fee
);
   logic [7:0] count;  // Two's complement count

   // Wrap is natural modular arithmetic, no saturation
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         count <= 8'h00;
      end else if (fee.clr) begin
         count <= 8'h00;
      end else if (fee.up && !fee.dn) begin
         count <= count + 8'h01;
      end else if (fee.dn && !fee.up) begin
         count <= count - 8'h01;
      end
   end
   assign fee.result = count;

   a_fee_wrap_down: assert property (@(posedge mclk) disable iff (rst)
      (count == 8'h80 && fee.dn && !fee.up && !fee.clr) |=> (count == 8'h7F))
      else $error("Counter did not wrap below minus 128");
   a_fee_wrap_up: assert property (@(posedge mclk) disable iff (rst)
      (count == 8'h7F && fee.up && !fee.dn && !fee.clr) |=> (count == 8'h80))
      else $error("Counter did not wrap above 127");
endmodule

// >>> hdl/ftc_top.sv
// Purpose: Transmit control: amplifier level, FSK divider select, data pin
// Assumes: Wishbone classic slave, inputs synchronous to mclk
// Notes:   Divider outputs feed the synthesizer directly
`timescale 1ns/10ps
module ftc_top
   import ftc_pkg::*;
(
   input  wire logic                 mclk,
   input  wire logic                 rst,
   input  wire logic                 wb_cyc_i,
   input  wire logic                 wb_stb_i,
   input  wire logic                 wb_we_i,
   input  wire logic [5:0]           wb_adr_i,
   input  wire logic [3:0]           wb_sel_i,
   input  wire logic [31:0]          wb_dat_i,
   output logic      [31:0]          wb_dat_o,
   output logic                      wb_ack_o,
   input  wire logic                 serial_data_pin_i,
   output logic                      serial_data_pin_o,
   output logic                      serial_data_pin_oe_n,
   input  wire logic                 rx_demod_data,
   input  wire logic                 fee_up_pulse,
   input  wire logic                 fee_dn_pulse,
   output logic                      pa_enable,
   output logic                      amplifier_bypass,
   output logic      [2:0]           tx_power_level,
   output logic                      low_noise_amp_bypass,
   output logic                      sync_mode_enable,
   output logic      [1:0]           operating_mode,
   output logic                      signal_strength_enable,
   output logic                      lock_detect_enable,
   output logic      [1:0]           prefilter_cutoff,
   output logic      [FTC_DIV_W-1:0] synth_divider
);
   logic [7:0]           cfg0;        // Power and mode config
   logic [7:0]           cfg1;        // Indicator and prefilter config
   logic [FTC_DIV_W-1:0] div_zero;    // M/N/A for data zero
   logic [FTC_DIV_W-1:0] div_one;     // M/N/A for data one
   logic                 bypass_reg;  // Amplifier bypass setting
   logic                 fee_clr;     // Write-pulse restart of counter
   logic                 wr_stb;      // Write commits on the ack edge
   logic                 tx_mode;     // Operating mode is transmit
   logic [31:0]          next_dat;    // Read mux
   ftc_fee_if            fee_bus ();

   // Commit only at the edge where the master samples ack high
   assign wr_stb  = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
   assign tx_mode = (cfg0[FTC_C0_MODE_HI:FTC_C0_MODE_LO] == FTC_MODE_TX);

   // Ack one cycle after request, dropped the cycle after
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      end
   end

   // Config zero; bit 0 always reads one
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         cfg0 <= FTC_C0_RST;
      end else if (wr_stb && wb_adr_i == FTC_ADR_CFG0 && wb_sel_i[0]) begin
         cfg0 <= wb_dat_i[7:0] | FTC_C0_FIXED;
      end
   end

   // Config one; bits 7..4 fixed at 1000
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         cfg1 <= FTC_C1_RST;
      end else if (wr_stb && wb_adr_i == FTC_ADR_CFG1 && wb_sel_i[0]) begin
         cfg1 <= {FTC_C1_FIXED[7:4], wb_dat_i[3:0]};
      end
   end

   // Divider sets, byte-lane writable; bit 24 of the status register holds bypass
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         div_zero   <= FTC_DIV_RST;
         div_one    <= FTC_DIV_RST;
         bypass_reg <= 1'b0;
      end else if (wr_stb) begin
         for (int b = 0; b < 3; b++) begin
            if (wb_sel_i[b] && wb_adr_i == FTC_ADR_DIV0) begin
               div_zero[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
            end
            if (wb_sel_i[b] && wb_adr_i == FTC_ADR_DIV1) begin
               div_one[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
            end
         end
         if (wb_sel_i[3] && wb_adr_i == FTC_ADR_STAT) begin
            bypass_reg <= wb_dat_i[24];
         end
      end
   end

   // Any write to the error register restarts the measurement
   assign fee_clr     = wr_stb && wb_adr_i == FTC_ADR_FEE;
   assign fee_bus.up  = fee_up_pulse;
   assign fee_bus.dn  = fee_dn_pulse;
   assign fee_bus.clr = fee_clr;

   ftc_fee_counter u_fee (
      .mclk (mclk),
      .rst  (rst),
      .fee  (fee_bus)
   );

   // Read mux; unmapped reads return zero
   always_comb begin
      next_dat = 32'h0000_0000;
      case (wb_adr_i)
         FTC_ADR_CFG0: next_dat[7:0] = cfg0;
         FTC_ADR_CFG1: next_dat[7:0] = cfg1;
         FTC_ADR_DIV0: next_dat[FTC_DIV_W-1:0] = div_zero;
         FTC_ADR_DIV1: next_dat[FTC_DIV_W-1:0] = div_one;
         FTC_ADR_FEE:  next_dat[7:0] = fee_bus.result;
         FTC_ADR_STAT: begin
            next_dat[FTC_ST_PA_ON]  = pa_enable;
            next_dat[FTC_ST_AMPLIFIER_BYPASS]  = amplifier_bypass;
            next_dat[FTC_ST_DATA]   = serial_data_pin_i;
            next_dat[FTC_ST_TXMODE] = tx_mode;
            next_dat[24]            = bypass_reg;
         end
         default: next_dat = 32'h0000_0000;
      endcase
   end

   // Registered read data
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_dat_o <= next_dat;
      end
   end

   // Amplifier controls; bypass keeps level scaling
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         pa_enable        <= 1'b0;
         amplifier_bypass <= 1'b0;
         tx_power_level   <= FTC_PWR_OFF;
      end else begin
         pa_enable        <= (cfg0[FTC_C0_PWR_HI:FTC_C0_PWR_LO] != FTC_PWR_OFF);
         amplifier_bypass <= bypass_reg;
         tx_power_level   <= cfg0[FTC_C0_PWR_HI:FTC_C0_PWR_LO];
      end
   end

   // Field fan-out of the config registers
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         low_noise_amp_bypass   <= 1'b0;
         sync_mode_enable       <= 1'b0;
         operating_mode         <= 2'b00;
         signal_strength_enable <= 1'b0;
         lock_detect_enable     <= 1'b0;
         prefilter_cutoff       <= 2'b00;
      end else begin
         low_noise_amp_bypass   <= cfg0[FTC_C0_LOW_NOISE_AMP_BYPASS];
         sync_mode_enable       <= cfg0[FTC_C0_SYNC];
         operating_mode         <= cfg0[FTC_C0_MODE_HI:FTC_C0_MODE_LO];
         signal_strength_enable <= cfg1[FTC_C1_RSSI];
         lock_detect_enable     <= cfg1[FTC_C1_LD];
         prefilter_cutoff       <= cfg1[1:0];
      end
   end

   // Divider select: one register stage, since the pin is synchronous already
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         synth_divider <= FTC_DIV_RST;
      end else if (tx_mode) begin
         synth_divider <= serial_data_pin_i ? div_one : div_zero;
      end else begin
         synth_divider <= div_zero;  // Receive LO uses set zero
      end
   end

   // Pin direction; enable low means driving
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         serial_data_pin_oe_n <= 1'b1;
         serial_data_pin_o    <= 1'b0;
      end else begin
         serial_data_pin_oe_n <= tx_mode || (operating_mode != FTC_MODE_RX);
         serial_data_pin_o    <= rx_demod_data;
      end
   end

   a_pa_off_zero: assert property (@(posedge mclk) disable iff (rst)
      (cfg0[6:4] == 3'h0) |=> !pa_enable)
      else $error("Amplifier on with zero power field");
   a_pa_on_nonzero: assert property (@(posedge mclk) disable iff (rst)
      (cfg0[6:4] != 3'h0) |=> (pa_enable && tx_power_level == $past(cfg0[6:4])))
      else $error("Amplifier level wrong for nonzero field");
   a_bypass_level: assert property (@(posedge mclk) disable iff (rst)
      (bypass_reg && cfg0[6:4] != 3'h0) |=> (amplifier_bypass && pa_enable))
      else $error("Bypass lost level control");
   a_div_select: assert property (@(posedge mclk) disable iff (rst)
      tx_mode |=> (synth_divider == ($past(serial_data_pin_i) ? $past(div_one)
                                                             : $past(div_zero))))
      else $error("Wrong divider set for data bit");
   a_div_follow: assert property (@(posedge mclk) disable iff (rst)
      (tx_mode && $changed(serial_data_pin_i) && div_zero != div_one) ##1 tx_mode
         |-> $changed(synth_divider))
      else $error("Divider select lagged data");
   a_pin_dir_tx: assert property (@(posedge mclk) disable iff (rst)
      tx_mode |=> serial_data_pin_oe_n)
      else $error("Data pin driven in transmit");
   a_pin_dir_rx: assert property (@(posedge mclk) disable iff (rst)
      (operating_mode == FTC_MODE_RX && !tx_mode) |=> !serial_data_pin_oe_n)
      else $error("Data pin not driven in receive");
   a_cfg0_fixed: assert property (@(posedge mclk) disable iff (rst)
      cfg0[0])
      else $error("Config zero bit 0 not one");
   a_cfg1_fixed: assert property (@(posedge mclk) disable iff (rst)
      cfg1[7:4] == 4'h8)
      else $error("Config one fixed bits wrong");
endmodule

// >>> verif/ftc_host_model.sv
// Purpose: Host side of the data pin and crystal tuning loop
// Assumes: Pin level is resolved here from both parties' enables
// Notes:   Undriven pin toggles each cycle so a stale value never passes
`timescale 1ns/10ps
module ftc_host_model
   import ftc_pkg::*;
(
   input  wire logic       mclk,
   input  wire logic       rst,
   input  wire logic [1:0] operating_mode,
   input  wire logic       serial_data_pin_oe_n,
   input  wire logic       serial_data_pin_o,
   input  wire logic       tx_bit,
   input  wire logic [7:0] fee_val,
   input  wire logic       fee_stb,
   output logic            pin_level,
   output logic      [7:0] xco_tune
);
   logic junk;  // Floating pin pattern

   // Pattern for an undriven pin
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         junk <= 1'b0;
      end else begin
         junk <= ~junk;
      end
   end

   // Host drives only in transmit mode, never while receiving
   assign pin_level = !serial_data_pin_oe_n ? serial_data_pin_o :
                      (operating_mode == FTC_MODE_TX) ? tx_bit : junk;

   // Steer tuning against the error sign; zero means aligned
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         xco_tune <= 8'h80;
      end else if (fee_stb && $signed(fee_val) > 0) begin
         xco_tune <= xco_tune - 8'h01;
      end else if (fee_stb && $signed(fee_val) < 0) begin
         xco_tune <= xco_tune + 8'h01;
      end
   end
endmodule

// >>> verif/testbench.sv
// Purpose: Self-checking bench for the FSK transmit control block
// Assumes: Wishbone classic master tasks, one clock domain
// Notes:   Random values from an eight-bit LFSR seeded at 25
`timescale 1ns/10ps
module testbench;
   import ftc_pkg::*;
   logic        mclk = 1'b0, rst = 1'b1;           // Clock and reset
   logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;  // Bus strobes
   logic [5:0]  adr = 6'h00;                        // Byte address
   logic [3:0]  sel = 4'h0;                         // Byte lanes
   logic [31:0] wdat = 32'h0000_0000, rdat, q;      // Bus data
   logic        ack, pin, pin_o, oe_n, pa_en, byp, lna, sync, rssi, ld;
   logic        rx_d = 1'b0, up = 1'b0, dn = 1'b0, tx_bit = 1'b0, fstb = 1'b0;
   logic [2:0]  pwr;                                // Power level
   logic [1:0]  mode, pfc;                          // Mode and prefilter
   logic [23:0] div, d0, d1;                        // Divider words
   logic [7:0]  r = 8'h19, fval = 8'h00, tune, e;  // LFSR state, misc
   int          bad_count = 0, compares = 0;

   always #5 mclk = ~mclk;

   ftc_top u_ftc_top (.mclk(mclk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .serial_data_pin_i(pin), .serial_data_pin_o(pin_o),
      .serial_data_pin_oe_n(oe_n), .rx_demod_data(rx_d), .fee_up_pulse(up),
      .fee_dn_pulse(dn), .pa_enable(pa_en), .amplifier_bypass(byp),
      .tx_power_level(pwr), .low_noise_amp_bypass(lna), .sync_mode_enable(sync),
      .operating_mode(mode), .signal_strength_enable(rssi), .lock_detect_enable(ld),
      .prefilter_cutoff(pfc), .synth_divider(div));

   ftc_host_model u_ftc_host_model (.mclk(mclk), .rst(rst), .operating_mode(mode),
      .serial_data_pin_oe_n(oe_n), .serial_data_pin_o(pin_o), .tx_bit(tx_bit),
      .fee_val(fval), .fee_stb(fstb), .pin_level(pin), .xco_tune(tune));

   // Next random byte
   function automatic logic [7:0] lfsr(input logic [7:0] v);
      return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
   endfunction

   task automatic tick(input int k);
      repeat (k) @(posedge mclk);
   endtask

   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      compares++;
      if (g !== x) begin
         bad_count++;
         $display("Error t=%0t got %h exp %h", $time, g, x);
      end
   endtask

   // One classic cycle; holds everything until ack is sampled
   task automatic wb(input logic w, input logic [5:0] a, input logic [31:0] d,
                     input logic [3:0] s);
      int n;
      n = 0;
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= s;
      do begin
         @(posedge mclk);
         n++;
      end while (ack !== 1'b1 && n < 50);
      if (n >= 50) chk(32'h0, 32'h1);
      q = rdat;
      cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
      @(posedge mclk);
   endtask

   // Count pulses with a gap between them, so each is one cycle
   task automatic pulse(input logic u, input logic dd, input int n);
      repeat (n) begin
         up <= u; dn <= dd;
         @(posedge mclk);
         up <= 1'b0; dn <= 1'b0;
         @(posedge mclk);
      end
   endtask

   task final_report;
      $display("compares=%0d bad_count=%0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   // Watchdog well beyond the expected run time
   initial begin
      #300_000;
      bad_count++;
      final_report;
   end

   initial begin
      tick(10);
      rst <= 1'b0;
      @(posedge mclk);
      wb(1'b0, FTC_ADR_CFG0, 32'h0, 4'hF); chk(q[7:0], FTC_C0_RST);
      wb(1'b0, FTC_ADR_CFG1, 32'h0, 4'hF); chk(q[7:0], FTC_C1_RST);
      // Every power code, bypass random, transmit mode
      for (int p = 0; p < 8; p++) begin
         r = lfsr(r);
         wb(1'b1, FTC_ADR_CFG0, {24'h0, 1'b0, 3'(p), 1'b0, FTC_MODE_TX, 1'b1}, 4'h1);
         wb(1'b1, FTC_ADR_STAT, {7'h0, r[0], 24'h0}, 4'h8);
         tick(2);
         chk(32'(pa_en), 32'(p != 0));
         chk(32'(pwr), 32'(p));
         chk(32'(byp), 32'(r[0]));
         wb(1'b0, FTC_ADR_STAT, 32'h0, 4'hF);
         chk(q, {7'h0, r[0], 20'h0, 1'b1, tx_bit, r[0], p != 0});
      end
      $display("power test done");
      // Random field layouts, fixed bits forced
      repeat (6) begin
         r = lfsr(r); e = lfsr(r);
         wb(1'b1, FTC_ADR_CFG0, {24'h0, r}, 4'h1);
         wb(1'b1, FTC_ADR_CFG1, {24'h0, e}, 4'h1);
         tick(2);
         chk(32'({lna, pwr, sync, mode}), 32'(r[7:1]));
         chk(32'({rssi, ld, pfc}), 32'(e[3:0]));
         wb(1'b0, FTC_ADR_CFG0, 32'h0, 4'hF); chk(q[7:0], r | 8'h01);
         wb(1'b0, FTC_ADR_CFG1, 32'h0, 4'hF); chk(q[7:0], {4'h8, e[3:0]});
         r = e;
      end
      $display("field test done");
      // Two divider sets switched by the data pin
      r = lfsr(r); d0[23:16] = r; r = lfsr(r); d0[15:8] = r; r = lfsr(r); d0[7:0] = r;
      r = lfsr(r); d1[23:16] = r; r = lfsr(r); d1[15:8] = r; r = lfsr(r); d1[7:0] = r;
      wb(1'b1, FTC_ADR_DIV0, {8'h0, d0}, 4'h7);
      wb(1'b1, FTC_ADR_DIV1, {8'h0, d1}, 4'h7);
      wb(1'b1, FTC_ADR_CFG0, 32'h0000_0025, 4'h1);
      repeat (8) begin
         r = lfsr(r);
         tx_bit <= r[0];
         tick(2);
         chk(32'(div), 32'(r[0] ? d1 : d0));
      end
      wb(1'b1, FTC_ADR_CFG0, 32'h0000_0023, 4'h1);
      tick(2);
      chk(32'(oe_n), 32'h0);
      repeat (4) begin
         r = lfsr(r);
         rx_d <= r[1];
         tick(2);
         chk(32'(pin_o), 32'(r[1]));
         chk(32'(div), 32'(d0));
      end
      wb(1'b1, FTC_ADR_CFG0, 32'h0000_0021, 4'h1);
      tick(2);
      chk(32'(oe_n), 32'h1);
      $display("divider and pin test done");
      // Error counter limits and wrap; host steers tuning against the error sign
      wb(1'b1, FTC_ADR_FEE, 32'h0, 4'hF);
      pulse(1'b0, 1'b1, 128);
      wb(1'b0, FTC_ADR_FEE, 32'h0, 4'hF); chk(q[7:0], 8'h80);
      pulse(1'b0, 1'b1, 2);
      wb(1'b0, FTC_ADR_FEE, 32'h0, 4'hF); chk(q[7:0], 8'h7E);
      fval <= q[7:0]; fstb <= 1'b1;
      @(posedge mclk);
      fstb <= 1'b0;
      wb(1'b1, FTC_ADR_FEE, 32'h0, 4'hF);
      chk(32'(tune), 32'h7F);
      pulse(1'b1, 1'b0, 127);
      pulse(1'b1, 1'b1, 3);
      wb(1'b0, FTC_ADR_FEE, 32'h0, 4'hF); chk(q[7:0], 8'h7F);
      pulse(1'b1, 1'b0, 1);
      wb(1'b0, FTC_ADR_FEE, 32'h0, 4'hF); chk(q[7:0], 8'h80);
      // Negative error must raise the tuning value back
      fval <= q[7:0]; fstb <= 1'b1;
      @(posedge mclk);
      fstb <= 1'b0;
      tick(1);
      chk(32'(tune), 32'h80);
      $display("error counter test done");
      // Unmapped places read as zero and are still answered
      wb(1'b1, 6'h20, 32'hFFFF_FFFF, 4'hF);
      wb(1'b0, 6'h20, 32'h0, 4'hF); chk(q, 32'h0000_0000);
      wb(1'b0, 6'h3C, 32'h0, 4'hF); chk(q, 32'h0000_0000);
      $display("unmapped test done");
      final_report;
   end
endmodule
